// file: bench/scl_config_latches_properties.sv
// scl_config_latches_properties: port-level checks of the config latch bank
// assumes two channels and a bind from the bench top file
`timescale 1ns/100ps
`default_nettype none
module scl_config_latches_properties (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic config_write_strobe_n,
    input wire scl_pkg::scl_addr_t config_addr,
    input wire scl_pkg::scl_data_t config_data,
    input wire logic [1:0] tx_input_clock,
    input wire logic [1:0] tx_shifter_data,
    input wire logic [1:0] rx_recovered_clock,
    input wire logic [1:0] rx_recovered_data,
    input wire logic [1:0] tx_primary_serial_out,
    input wire logic [1:0] tx_primary_powerdown,
    input wire logic [1:0] tx_secondary_powerdown,
    input wire logic [1:0] tx_channel_powerdown,
    input wire logic [1:0] phase_recenter_pulse,
    input wire logic [1:0] rx_output_clock_p,
    input wire logic [1:0] rx_output_clock_n,
    input wire logic [1:0] reclock_primary_out,
    input wire logic [1:0] reclock_primary_powerdown,
    input wire logic [1:0] reclock_secondary_out,
    input wire logic [1:0] reclock_secondary_powerdown
);
    import scl_pkg::*;
    logic rate_r;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // mirror of channel C receive clock rate select, reset to half rate
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) rate_r <= 1'b1;
        else if (!config_write_strobe_n && config_addr == 4'h6) rate_r <= config_data[0];
    end
    // output and power relations
    property p_tx_out; tx_primary_serial_out == $past(~tx_primary_powerdown & tx_shifter_data); endproperty
    a_tx_out: assert property (p_tx_out) else $error("tx serial out wrong");
    property p_ch_pd; tx_channel_powerdown == (tx_primary_powerdown & tx_secondary_powerdown); endproperty
    a_ch_pd: assert property (p_ch_pd) else $error("channel power down wrong");
    property p_wr; (!config_write_strobe_n && config_addr == 4'h2) |=> tx_primary_powerdown[0] == !$past(config_data[1]); endproperty
    a_wr: assert property (p_wr) else $error("bank write not taken");
    property p_indep; (!config_write_strobe_n && config_addr == 4'h2) |=> $stable(tx_primary_powerdown[1]); endproperty
    a_indep: assert property (p_indep) else $error("other channel changed");
    property p_pulse; phase_recenter_pulse[0] |=> !phase_recenter_pulse[0]; endproperty
    a_pulse: assert property (p_pulse) else $error("recenter pulse too long");
    property p_sync; $rose(phase_recenter_pulse[0]) |-> $past(tx_input_clock[0]) && !$past(tx_input_clock[0], 2); endproperty
    a_sync: assert property (p_sync) else $error("recenter without clock rise");
    property p_compl; rx_output_clock_n == ~rx_output_clock_p; endproperty
    a_compl: assert property (p_compl) else $error("rx clock pair not complementary");
    property p_full; !$past(rate_r) |-> rx_output_clock_p[0] == $past(rx_recovered_clock[0]); endproperty
    a_full: assert property (p_full) else $error("full rate clock wrong");
    property p_half; $past(rate_r) && $past(resetn, 2) && $past(rx_recovered_clock[0]) && !$past(rx_recovered_clock[0], 2) |-> rx_output_clock_p[0] != $past(rx_output_clock_p[0]); endproperty
    a_half: assert property (p_half) else $error("half rate clock did not toggle");
    property p_rck; reclock_primary_out == $past(~reclock_primary_powerdown & rx_recovered_data); endproperty
    a_rck: assert property (p_rck) else $error("reclock out wrong");
    property p_rck2; reclock_secondary_out == $past(~reclock_secondary_powerdown & rx_recovered_data); endproperty
    a_rck2: assert property (p_rck2) else $error("reclock secondary out wrong");
endmodule : scl_config_latches_properties
`default_nettype wire

// file: bench/scl_host.sv
// scl_host: host controller model driving the config latch port
// assumes the bench calls write; speed range select is high on the board
`timescale 1ns/100ps
`default_nettype none
module scl_host (
    input wire logic ref_clk,
    output logic config_write_strobe_n,
    output scl_pkg::scl_addr_t config_addr,
    output scl_pkg::scl_data_t config_data
);
    import scl_pkg::*;
    // idle port
    initial begin
        config_write_strobe_n = 1'b1;
        config_addr = 4'h0;
        config_data = 8'h00;
    end
    // one write held over one edge, then released with a changed bus
    task automatic write(input scl_addr_t a, input scl_data_t d);
        @(posedge ref_clk);
        config_write_strobe_n <= 1'b0;
        config_addr <= a;
        config_data <= (a == 4'h6 || a == 4'h9) ? (8'h40 | (d & 8'h01)) : d; // fixed bits kept
        @(posedge ref_clk);
        config_write_strobe_n <= 1'b1;
        config_addr <= ~a;
        config_data <= ~config_data;
    endtask : write
endmodule : scl_host
`default_nettype wire

// file: bench/tb_scl_config_latches.sv
// tb_scl_config_latches: self-checking bench for the config latch bank
// assumes the host model drives the port and the checker is bound below
`timescale 1ns/100ps
`default_nettype none
module tb_scl_config_latches;
    import scl_pkg::*;
    typedef struct {int sel; logic [7:0] exp;} scl_note_s;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic [1:0] tx_input_clock = 2'h0, tx_shifter_data = 2'h0, rx_recovered_clock = 2'h0, rx_recovered_data = 2'h0;
    logic config_write_strobe_n;
    scl_addr_t config_addr;
    scl_data_t config_data;
    logic [1:0] tx_primary_serial_out, tx_primary_powerdown, tx_secondary_powerdown, tx_channel_powerdown;
    logic [1:0] phase_recenter_pulse, rx_output_clock_p, rx_output_clock_n, primary_detect_enable;
    logic [1:0] secondary_detect_enable, training_clock_multiplier, rx_channel_power_enable, rx_bist_enable;
    logic [1:0] rx_mode_invalid, reclock_primary_out, reclock_secondary_out, reclock_primary_powerdown;
    logic [1:0] reclock_secondary_powerdown, rx_reclock_powerdown, tp, ts, mult, pwr, r1, r2;
    logic [3:0] primary_detect_threshold, secondary_detect_threshold, rx_mode_select, d1, d2, md;
    logic [7:0] pcnt = 8'h00;
    logic [7:0] obs [6];
    scl_note_s notes [$];
    scl_note_s n;
    int bad_count = 0, comparisons = 0, cyc = 0;
    string nm [6] = '{"tx_pd", "thresholds", "rx_mode", "rx_ctrl", "rx_pd_det", "recenter"};
    scl_config_latches dut (.ref_clk, .resetn, .config_write_strobe_n, .config_addr, .config_data,
        .tx_input_clock, .tx_shifter_data, .rx_recovered_clock, .rx_recovered_data, .tx_primary_serial_out,
        .tx_primary_powerdown, .tx_secondary_powerdown, .tx_channel_powerdown, .phase_recenter_pulse,
        .rx_output_clock_p, .rx_output_clock_n, .primary_detect_threshold, .secondary_detect_threshold,
        .primary_detect_enable, .secondary_detect_enable, .training_clock_multiplier, .rx_channel_power_enable,
        .rx_mode_select, .rx_bist_enable, .rx_mode_invalid, .reclock_primary_out, .reclock_secondary_out,
        .reclock_primary_powerdown, .reclock_secondary_powerdown, .rx_reclock_powerdown);
    scl_host host (.ref_clk, .config_write_strobe_n, .config_addr, .config_data);
    // observed output groups
    assign obs[0] = {2'h0, tx_primary_powerdown, tx_secondary_powerdown, tx_channel_powerdown};
    assign obs[1] = {secondary_detect_threshold, primary_detect_threshold};
    assign obs[2] = {rx_mode_select, rx_bist_enable, rx_mode_invalid};
    assign obs[3] = {training_clock_multiplier, rx_channel_power_enable, reclock_primary_powerdown, reclock_secondary_powerdown};
    assign obs[4] = {rx_reclock_powerdown, primary_detect_enable, secondary_detect_enable, 2'h0};
    assign obs[5] = pcnt;
    // expected group value from the latch model
    function automatic logic [7:0] expv(input int s);
        logic [1:0] bi, iv, e1, e2;
        for (int c = 0; c < 2; c++) begin
            bi[c] = md[2*c+:2] == 2'h2;
            iv[c] = md[2*c+:2] == 2'h0 || md[2*c+:2] == 2'h3;
            e1[c] = d1[2*c+:2] != 2'h0;
            e2[c] = d2[2*c+:2] != 2'h0;
        end
        case (s)
            0: return {2'h0, ~tp, ~ts, ~tp & ~ts};
            1: return {d2, d1};
            2: return {md, bi, iv};
            3: return {mult, pwr, ~r1, ~r2};
            default: return {~r1 & ~r2, e1, e2, 2'h0};
        endcase
    endfunction : expv
    // latch model reset and update
    task automatic mreset();
        {tp, ts, mult, pwr, r1, r2} = 12'h000;
        {d1, d2, md} = 12'haaf;
    endtask : mreset
    task automatic wr(input scl_addr_t a, input scl_data_t d);
        int c;
        c = (a == 4'h5 || a == 4'ha || a == 4'hb) ? 1 : 0;
        host.write(a, d);
        if (a == 4'h2 || a == 4'h5) {ts[c], tp[c]} = d[2:1];
        if (a == 4'h7 || a == 4'ha) {d2[2*c+:2], d1[2*c+:2], mult[c]} = {d[6:3], d[0]};
        if (a == 4'h8 || a == 4'hb) {md[2*c+:2], pwr[c], r2[c], r1[c]} = {d[6], d[4], d[5], d[2:1]};
    endtask : wr
    task automatic note_all();
        for (int s = 0; s < 5; s++) notes.push_back('{s, expv(s)});
    endtask : note_all
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input int s);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm[s], exp, seen);
        end
    endtask : chk
    task automatic test_done();
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done
    // compare every pending note at the falling edge
    always @(negedge ref_clk) begin
        while (notes.size() > 0) begin
            n = notes.pop_front();
            chk(obs[n.sel], n.exp, n.sel);
        end
    end
    initial begin
        forever #50 ref_clk = ~ref_clk;
    end
    // random channel levels, pulse counter and hang guard
    always @(posedge ref_clk) begin
        tx_shifter_data <= 2'($urandom);
        rx_recovered_data <= 2'($urandom);
        rx_recovered_clock <= 2'($urandom);
        pcnt <= pcnt + 8'(phase_recenter_pulse[0]) + 8'h10 * 8'(phase_recenter_pulse[1]);
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            bad_count++;
            test_done();
        end
    end
    // main sequence
    initial begin
        void'($urandom(32'h2ff1));
        mreset();
        repeat (7) @(posedge ref_clk);
        note_all();
        @(posedge ref_clk);
        resetn <= 1'b1;
        for (int i = 0; i < 40; i++) begin
            wr(scl_addr_t'($urandom % 12), 8'($urandom));
            note_all();
        end
        wr(4'h6, 8'h40);
        repeat (20) @(posedge ref_clk);
        resetn <= 1'b0;
        mreset();
        note_all();
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
        wr(4'h2, 8'h02);
        note_all();
        for (int k = 0; k < 4; k++) begin
            repeat (3) @(posedge ref_clk);
            tx_input_clock[0] <= ~tx_input_clock[0];
        end
        repeat (3) @(posedge ref_clk);
        notes.push_back('{5, 8'h01});
        wr(4'h8, 8'h32);
        note_all();
        repeat (20) @(posedge ref_clk);
        test_done();
    end
endmodule : tb_scl_config_latches
bind scl_config_latches scl_config_latches_properties chk_i (.ref_clk, .resetn, .config_write_strobe_n,
    .config_addr, .config_data, .tx_input_clock, .tx_shifter_data, .rx_recovered_clock, .rx_recovered_data,
    .tx_primary_serial_out, .tx_primary_powerdown, .tx_secondary_powerdown, .tx_channel_powerdown,
    .phase_recenter_pulse, .rx_output_clock_p, .rx_output_clock_n, .reclock_primary_out,
    .reclock_primary_powerdown, .reclock_secondary_out, .reclock_secondary_powerdown);
`default_nettype wire

// file: core/scl_config_latches.sv
// scl_config_latches: write-only per-channel config latches and the logic they steer
// assumes all inputs synchronous to ref_clk; channel clocks arrive as sampled levels
`include "scl_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module scl_config_latches #(
    parameter int NCH = 2
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic config_write_strobe_n,
    input wire scl_pkg::scl_addr_t config_addr,
    input wire scl_pkg::scl_data_t config_data,
    input wire logic [NCH-1:0] tx_input_clock,
    input wire logic [NCH-1:0] tx_shifter_data,
    input wire logic [NCH-1:0] rx_recovered_clock,
    input wire logic [NCH-1:0] rx_recovered_data,
    output logic [NCH-1:0] tx_primary_serial_out,
    output logic [NCH-1:0] tx_primary_powerdown,
    output logic [NCH-1:0] tx_secondary_powerdown,
    output logic [NCH-1:0] tx_channel_powerdown,
    output logic [NCH-1:0] phase_recenter_pulse,
    output logic [NCH-1:0] rx_output_clock_p,
    output logic [NCH-1:0] rx_output_clock_n,
    output logic [2*NCH-1:0] primary_detect_threshold,
    output logic [2*NCH-1:0] secondary_detect_threshold,
    output logic [NCH-1:0] primary_detect_enable,
    output logic [NCH-1:0] secondary_detect_enable,
    output logic [NCH-1:0] training_clock_multiplier,
    output logic [NCH-1:0] rx_channel_power_enable,
    output logic [2*NCH-1:0] rx_mode_select,
    output logic [NCH-1:0] rx_bist_enable,
    output logic [NCH-1:0] rx_mode_invalid,
    output logic [NCH-1:0] reclock_primary_out,
    output logic [NCH-1:0] reclock_secondary_out,
    output logic [NCH-1:0] reclock_primary_powerdown,
    output logic [NCH-1:0] reclock_secondary_powerdown,
    output logic [NCH-1:0] rx_reclock_powerdown
);
    import scl_pkg::*;

    // only two channels per direction own bank addresses, so refuse any other count
    if (NCH != 2) begin : g_bad_nch
        $error("scl_config_latches serves exactly two channels per direction");
    end

    // one bank address per channel and bank kind
    localparam scl_addr_t TXDYN [2] = '{`SCL_BANK_TXDYN_0, `SCL_BANK_TXDYN_1};
    localparam scl_addr_t RXRATE [2] = '{`SCL_BANK_RXRATE_0, `SCL_BANK_RXRATE_1};
    localparam scl_addr_t RXSTAT [2] = '{`SCL_BANK_RXSTAT_0, `SCL_BANK_RXSTAT_1};
    localparam scl_addr_t RXDYN [2] = '{`SCL_BANK_RXDYN_0, `SCL_BANK_RXDYN_1};

    // write hit for one bank while the strobe is low
    function automatic logic bank_hit(input logic strobe_n, input scl_addr_t a,
                                      input scl_addr_t bank);
        bank_hit = !strobe_n && (a == bank);
    endfunction : bank_hit

    // a level seen high at this edge and low at the previous one
    function automatic logic rose_now(input logic now_lvl, input logic was_lvl);
        rose_now = now_lvl && !was_lvl;
    endfunction : rose_now

    // latch storage
    logic [NCH-1:0] tx_pri_r;
    logic [NCH-1:0] tx_sec_r;
    logic [NCH-1:0] recenter_r;
    logic [NCH-1:0] rx_rate_r;
    logic [1:0] det1_r [NCH];
    logic [1:0] det2_r [NCH];
    logic [NCH-1:0] trg_r;
    logic [NCH-1:0] pwr_r;
    logic [1:0] mode_r [NCH];
    logic [NCH-1:0] rck_pri_r;
    logic [NCH-1:0] rck_sec_r;
    // channel clock history and derived state
    logic [NCH-1:0] txclk_d_r;
    logic [NCH-1:0] rxclk_d_r;
    logic [NCH-1:0] tx_out_r;
    logic [NCH-1:0] rck1_out_r;
    logic [NCH-1:0] rck2_out_r;
    logic [NCH-1:0] pulse_r;
    logic [NCH-1:0] ckp_r;
    logic [NCH-1:0] ckn_r;

    // decoded write hits and edges
    wire [NCH-1:0] hit_tx;
    wire [NCH-1:0] hit_rate;
    wire [NCH-1:0] hit_stat;
    wire [NCH-1:0] hit_rx;
    wire [NCH-1:0] txclk_rise;
    wire [NCH-1:0] rxclk_rise;
    wire [NCH-1:0] recenter_use;

    // data bus fields, one copy shared by every bank of the same kind
    wire data_recenter = config_data[`SCL_BIT_RECENTER];
    wire data_tx_pri = config_data[`SCL_BIT_TX_PRI];
    wire data_tx_sec = config_data[`SCL_BIT_TX_SEC];
    wire data_rx_rate = config_data[`SCL_BIT_RX_RATE];
    wire data_trg = config_data[`SCL_BIT_TRG_MULT];
    wire [1:0] data_det1 = config_data[`SCL_BIT_DET1_HI:`SCL_BIT_DET1_LO];
    wire [1:0] data_det2 = config_data[`SCL_BIT_DET2_HI:`SCL_BIT_DET2_LO];
    wire data_rck_pri = config_data[`SCL_BIT_RCK_PRI];
    wire data_rck_sec = config_data[`SCL_BIT_RCK_SEC];
    wire data_pwr = config_data[`SCL_BIT_PWR];
    wire [1:0] data_mode = {config_data[`SCL_BIT_MODE_HI], config_data[`SCL_BIT_MODE_LO]};

    // next values of the registered serial drivers
    wire [NCH-1:0] tx_out_nxt;
    wire [NCH-1:0] rck1_out_nxt;
    wire [NCH-1:0] rck2_out_nxt;

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            // per-channel bank decode keeps channels apart
            assign hit_tx[g] = bank_hit(config_write_strobe_n, config_addr, TXDYN[g]);
            assign hit_rate[g] = bank_hit(config_write_strobe_n, config_addr, RXRATE[g]);
            assign hit_stat[g] = bank_hit(config_write_strobe_n, config_addr, RXSTAT[g]);
            assign hit_rx[g] = bank_hit(config_write_strobe_n, config_addr, RXDYN[g]);
            assign txclk_rise[g] = rose_now(tx_input_clock[g], txclk_d_r[g]);
            assign rxclk_rise[g] = rose_now(rx_recovered_clock[g], rxclk_d_r[g]);
            // disabled drivers hold low instead of passing data
            assign tx_out_nxt[g] = tx_pri_r[g] && tx_shifter_data[g];
            assign rck1_out_nxt[g] = rck_pri_r[g] && rx_recovered_data[g];
            assign rck2_out_nxt[g] = rck_sec_r[g] && rx_recovered_data[g];
            // a low latch is consumed on the next transmit clock rise
            assign recenter_use[g] = txclk_rise[g] && !recenter_r[g];

            // transmit dynamic bank
            always_ff @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    tx_pri_r[g] <= `SCL_RST_TX_PRI;
                    tx_sec_r[g] <= `SCL_RST_TX_SEC;
                    recenter_r[g] <= `SCL_RST_RECENTER;
                end else if (hit_tx[g]) begin
                    // a host write wins over the self clear: it is a fresh request
                    tx_pri_r[g] <= data_tx_pri;
                    tx_sec_r[g] <= data_tx_sec;
                    recenter_r[g] <= data_recenter;
                end else if (recenter_use[g]) begin
                    recenter_r[g] <= 1'b1;
                end
            end

            // receive static banks
            always_ff @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    rx_rate_r[g] <= `SCL_RST_RX_RATE;
                    det1_r[g] <= `SCL_RST_DET;
                    det2_r[g] <= `SCL_RST_DET;
                    trg_r[g] <= `SCL_RST_TRG_MULT;
                end else begin
                    if (hit_rate[g]) begin
                        rx_rate_r[g] <= data_rx_rate;
                    end
                    if (hit_stat[g]) begin
                        trg_r[g] <= data_trg;
                        det1_r[g] <= data_det1;
                        det2_r[g] <= data_det2;
                    end
                end
            end

            // receive dynamic bank
            always_ff @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    pwr_r[g] <= `SCL_RST_PWR;
                    mode_r[g] <= `SCL_RST_MODE;
                    rck_pri_r[g] <= `SCL_RST_RCK;
                    rck_sec_r[g] <= `SCL_RST_RCK;
                end else if (hit_rx[g]) begin
                    pwr_r[g] <= data_pwr;
                    mode_r[g] <= data_mode;
                    rck_pri_r[g] <= data_rck_pri;
                    rck_sec_r[g] <= data_rck_sec;
                end
            end

            // channel clock history for edge detection
            always_ff @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    txclk_d_r[g] <= 1'b0;
                    rxclk_d_r[g] <= 1'b0;
                end else begin
                    txclk_d_r[g] <= tx_input_clock[g];
                    rxclk_d_r[g] <= rx_recovered_clock[g];
                end
            end

            // one-cycle realign pulse when the latch is consumed
            always_ff @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    pulse_r[g] <= 1'b0;
                end else begin
                    pulse_r[g] <= recenter_use[g];
                end
            end

            // serial drivers: data when enabled, held low when disabled
            always_ff @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    tx_out_r[g] <= 1'b0;
                    rck1_out_r[g] <= 1'b0;
                    rck2_out_r[g] <= 1'b0;
                end else begin
                    tx_out_r[g] <= tx_out_nxt[g];
                    rck1_out_r[g] <= rck1_out_nxt[g];
                    rck2_out_r[g] <= rck2_out_nxt[g];
                end
            end

            // receive clock pair: toggles per rise in half rate, follows in full rate
            // toggling the pair itself keeps it alternating right after a rate switch
            always_ff @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    ckp_r[g] <= 1'b0;
                    ckn_r[g] <= 1'b1;
                end else if (rx_rate_r[g]) begin
                    if (rxclk_rise[g]) begin
                        ckp_r[g] <= !ckp_r[g];
                        ckn_r[g] <= ckp_r[g];
                    end
                end else begin
                    // full rate re-reads the clock every edge, so a switch settles at once
                    ckp_r[g] <= rx_recovered_clock[g];
                    ckn_r[g] <= !rx_recovered_clock[g];
                end
            end

            // field outputs
            assign primary_detect_threshold[2*g +: 2] = det1_r[g];
            assign secondary_detect_threshold[2*g +: 2] = det2_r[g];
            assign primary_detect_enable[g] = det1_r[g] != 2'h0;
            assign secondary_detect_enable[g] = det2_r[g] != 2'h0;
            assign rx_mode_select[2*g +: 2] = mode_r[g];
            assign rx_bist_enable[g] = mode_r[g] == SCL_MODE_BIST;
            assign rx_mode_invalid[g] = mode_r[g] == SCL_MODE_BAD0 ||
                                        mode_r[g] == SCL_MODE_BAD3;
        end
    endgenerate

    // power-down and level outputs
    assign tx_primary_powerdown = ~tx_pri_r;
    assign tx_secondary_powerdown = ~tx_sec_r;
    assign tx_channel_powerdown = ~(tx_pri_r | tx_sec_r);
    assign reclock_primary_powerdown = ~rck_pri_r;
    assign reclock_secondary_powerdown = ~rck_sec_r;
    assign rx_reclock_powerdown = ~(rck_pri_r | rck_sec_r);
    assign training_clock_multiplier = trg_r;
    assign rx_channel_power_enable = pwr_r;
    assign phase_recenter_pulse = pulse_r;
    assign tx_primary_serial_out = tx_out_r;
    assign reclock_primary_out = rck1_out_r;
    assign reclock_secondary_out = rck2_out_r;
    assign rx_output_clock_p = ckp_r;
    assign rx_output_clock_n = ckn_r;
endmodule : scl_config_latches
`default_nettype wire

// file: core/scl_consts.svh
// scl_consts.svh: bank addresses, bit positions and reset values of the config latches
// assumes inclusion by bare name from the package and the latch bank module
`ifndef SCL_CONSTS_SVH
`define SCL_CONSTS_SVH

`define SCL_ADDR_W 4
`define SCL_DATA_W 8
// bank addresses, index 0 is channel A or C, index 1 channel B or D
`define SCL_BANK_TXDYN_0 4'h2
`define SCL_BANK_TXDYN_1 4'h5
`define SCL_BANK_RXRATE_0 4'h6
`define SCL_BANK_RXRATE_1 4'h9
`define SCL_BANK_RXSTAT_0 4'h7
`define SCL_BANK_RXSTAT_1 4'hA
`define SCL_BANK_RXDYN_0 4'h8
`define SCL_BANK_RXDYN_1 4'hB
// transmit dynamic bank bits
`define SCL_BIT_RECENTER 0
`define SCL_BIT_TX_PRI 1
`define SCL_BIT_TX_SEC 2
// receive static banks
`define SCL_BIT_RX_RATE 0
`define SCL_BIT_TRG_MULT 0
`define SCL_BIT_DET1_LO 3
`define SCL_BIT_DET1_HI 4
`define SCL_BIT_DET2_LO 5
`define SCL_BIT_DET2_HI 6
// receive dynamic bank
`define SCL_BIT_RCK_PRI 1
`define SCL_BIT_RCK_SEC 2
`define SCL_BIT_MODE_LO 4
`define SCL_BIT_PWR 5
`define SCL_BIT_MODE_HI 6
// reset values
`define SCL_RST_TX_PRI 1'b0
`define SCL_RST_TX_SEC 1'b0
`define SCL_RST_RECENTER 1'b1
`define SCL_RST_RX_RATE 1'b1
`define SCL_RST_DET 2'h2
`define SCL_RST_TRG_MULT 1'b0
`define SCL_RST_PWR 1'b0
`define SCL_RST_MODE 2'h3
`define SCL_RST_RCK 1'b0

`endif

// file: core/scl_pkg.sv
// scl_pkg: types shared by the config latch bank
// assumes scl_consts.svh is on the include path
`include "scl_consts.svh"
package scl_pkg;
    typedef logic [`SCL_ADDR_W-1:0] scl_addr_t;
    typedef logic [`SCL_DATA_W-1:0] scl_data_t;
    // receive mode codes
    typedef enum logic [1:0] {
        SCL_MODE_BAD0 = 2'h0,
        SCL_MODE_VIDEO = 2'h1,
        SCL_MODE_BIST = 2'h2,
        SCL_MODE_BAD3 = 2'h3
    } scl_mode_e;
endpackage : scl_pkg
